// ---- mcc_pkg.sv ----
// Package of register offsets, field positions, reset values and timing counts.
package mcc_pkg;
   localparam logic [1:0] ADDR_CTRL_STATUS = 2'h0;
   localparam logic [1:0] ADDR_TONE        = 2'h1;
   localparam logic [1:0] ADDR_IRQ_STATUS  = 2'h2;
   localparam logic [1:0] ADDR_IRQ_MASK    = 2'h3;
   localparam int BIT_CLK_OUT   = 7;
   localparam int BIT_DIV_HI    = 6;
   localparam int BIT_DIV_LO    = 5;
   localparam int BIT_SLOW      = 4;
   localparam int BIT_PER_HI    = 3;
   localparam int BIT_PER_LO    = 2;
   localparam int BIT_PER_IE    = 1;
   localparam int BIT_PER_FLAG  = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] TONE_RESET = 8'h00;
   localparam logic [1:0] TONE_FIELD_MASK = 2'h3;
   localparam int PERIOD_0 = 16000;
   localparam int PERIOD_1 = 32000;
   localparam int PERIOD_2 = 80000;
   localparam int PERIOD_3 = 200000;
   localparam int CLOCK_HZ = 100000000;
   localparam int TONE_2K_HZ  = 2000;
   localparam int TONE_1K_HZ  = 1000;
   localparam int TONE_500_HZ = 500;
   localparam int TONE_HALF_2K  = CLOCK_HZ / (2 * TONE_2K_HZ);
   localparam int TONE_HALF_1K  = CLOCK_HZ / (2 * TONE_1K_HZ);
   localparam int TONE_HALF_500 = CLOCK_HZ / (2 * TONE_500_HZ);
endpackage : mcc_pkg

// ---- mcc_clock_controller.sv ----
// Main clock controller: core clock prescaler, clock out, time base, tone.
//
// Contract
// - Prescaler, clock out, time base and tone run independently and together.
// - Slow select clear gives core clock equal to oscillator clock.
// - Slow mode divides by 2, 4, 8 or 16 per divider select.
// - Clock out select drives the clock onto the pin, else pin free.
// - Clock out pin stops toggling during active halt.
// - Time base period is 16000, 32000, 80000 or 200000 cycles.
// - A new period selection applies only after the current period ends.
// - Period flag sets on period end, clears when status register is read.
// - Interrupt request asserted while flag and enable are both set.
// - Halt with enable set enters active halt instead of full halt.
// - Wait mode leaves the block running; period interrupt exits wait.
// - Active halt keeps counter running, freezes registers, irq wakes.
// - Full halt freezes counter and registers until external wake.
// - Period interrupt wakes from wait and active halt, never full halt.
// - Tone pin drives one of three selectable tones as alternate function.
// - Tone select: off, about 2 kHz, 1 kHz, 500 Hz, half duty.
// - Control and status register resets to all zeros.
module mcc_clock_controller #(
   parameter int PERIOD_COUNT_0 = mcc_pkg::PERIOD_0,
   parameter int PERIOD_COUNT_1 = mcc_pkg::PERIOD_1,
   parameter int PERIOD_COUNT_2 = mcc_pkg::PERIOD_2,
   parameter int PERIOD_COUNT_3 = mcc_pkg::PERIOD_3
) (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic [1:0] regAddr,
   input  wire logic [7:0] regWrData,
   input  wire logic       regWrite,
   input  wire logic       regRead,
   output logic      [7:0] regRdData,
   input  wire logic       haltRequest,
   input  wire logic       wakeExternal,
   input  wire logic       waitMode,
   output logic            coreClockEnable,
   output logic            clockOutPin,
   output logic            clockOutEnable,
   output logic            tonePin,
   output logic            toneEnable,
   output logic            periodIrq,
   output logic            activeHalt,
   output logic            fullHalt,
   output logic            wakeRequest,
   output logic            irqOut
);
   typedef enum logic [1:0] {MCC_RUN, MCC_ACTIVE_HALT, MCC_FULL_HALT} mcc_pwr_t;

   mcc_pwr_t    pwr_r;
   mcc_pwr_t    pwr_nxt;
   logic [7:0]  ctrl_r;
   logic [1:0]  tone_r;
   logic [1:0]  irqStat_r;
   logic [1:0]  irqMask_r;
   logic [17:0] perCnt_r;
   logic [1:0]  perSel_r;
   logic [3:0]  preCnt_r;
   logic        coreEn_r;
   logic        clkOut_r;
   logic [16:0] toneCnt_r;
   logic        tone_r_lvl;
   logic [7:0]  rdData_r;
   logic [1:0]  wakeExtSync_r;
   logic [1:0]  haltSync_r;
   logic        haltSeen_r;

   wire         haltReqS   = haltSync_r[1];
   wire         wakeExtS   = wakeExtSync_r[1];
   wire         regsFrozen = (pwr_r != MCC_RUN);
   wire         cntRunning = (pwr_r != MCC_FULL_HALT);
   wire         wrCtrl     = regWrite && !regsFrozen
                             && regAddr == mcc_pkg::ADDR_CTRL_STATUS;
   wire         wrTone     = regWrite && !regsFrozen
                             && regAddr == mcc_pkg::ADDR_TONE;
   wire         wrMask     = regWrite && !regsFrozen
                             && regAddr == mcc_pkg::ADDR_IRQ_MASK;
   wire         rdCtrl     = regRead && regAddr == mcc_pkg::ADDR_CTRL_STATUS;
   wire         rdIrqStat  = regRead && regAddr == mcc_pkg::ADDR_IRQ_STATUS;
   wire [1:0]   slowSel    = ctrl_r[mcc_pkg::BIT_DIV_HI:mcc_pkg::BIT_DIV_LO];
   wire [1:0]   perSelNew  = ctrl_r[mcc_pkg::BIT_PER_HI:mcc_pkg::BIT_PER_LO];
   wire         perIe      = ctrl_r[mcc_pkg::BIT_PER_IE];
   wire         perFlag    = ctrl_r[mcc_pkg::BIT_PER_FLAG];
   wire         slowMode   = ctrl_r[mcc_pkg::BIT_SLOW];

   // Terminal count of the period in progress, not of the newest write.
   wire [17:0]  perTerm =
      (perSel_r == 2'h0) ? 18'(PERIOD_COUNT_0 - 1) :
      (perSel_r == 2'h1) ? 18'(PERIOD_COUNT_1 - 1) :
      (perSel_r == 2'h2) ? 18'(PERIOD_COUNT_2 - 1) :
                           18'(PERIOD_COUNT_3 - 1);
   wire         perEvent = cntRunning && perCnt_r == perTerm;

   // Slow-mode division: enable once every 2^(sel+1) oscillator cycles.
   wire [3:0]   preMask = (4'h2 << slowSel) - 4'h1;
   wire         preWrap = (preCnt_r & preMask) == preMask;

   wire [16:0]  toneHalf =
      (tone_r == 2'h1) ? 17'(mcc_pkg::TONE_HALF_2K - 1) :
      (tone_r == 2'h2) ? 17'(mcc_pkg::TONE_HALF_1K - 1) :
                         17'(mcc_pkg::TONE_HALF_500 - 1);
   wire         toneOn  = tone_r != 2'h0;

   wire [7:0]   rdMux =
      (regAddr == mcc_pkg::ADDR_CTRL_STATUS) ? ctrl_r :
      (regAddr == mcc_pkg::ADDR_TONE)        ? {6'h00, tone_r} :
      (regAddr == mcc_pkg::ADDR_IRQ_STATUS)  ? {6'h00, irqStat_r} :
                                               {6'h00, irqMask_r};

   always_ff @(posedge clock) begin
      if (rst) begin
         wakeExtSync_r <= 2'h0;
         haltSync_r    <= 2'h0;
         haltSeen_r    <= 1'b0;
      end else begin
         wakeExtSync_r <= {wakeExtSync_r[0], wakeExternal};
         haltSync_r    <= {haltSync_r[0], haltRequest};
         haltSeen_r    <= haltReqS;
      end
   end

   wire haltEdge = haltReqS && !haltSeen_r;

   always_comb begin
      pwr_nxt = pwr_r;
      case (pwr_r)
         MCC_RUN: begin
            if (haltEdge) begin
               pwr_nxt = perIe ? MCC_ACTIVE_HALT : MCC_FULL_HALT;
            end
         end
         MCC_ACTIVE_HALT: begin
            if (periodIrq || wakeExtS) begin
               pwr_nxt = MCC_RUN;
            end
         end
         MCC_FULL_HALT: begin
            if (wakeExtS) begin
               pwr_nxt = MCC_RUN;
            end
         end
         default: pwr_nxt = MCC_RUN;
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         pwr_r <= MCC_RUN;
      end else begin
         pwr_r <= pwr_nxt;
      end
   end

   // Control register; the hardware flag set wins over a clearing read.
   always_ff @(posedge clock) begin
      if (rst) begin
         ctrl_r <= mcc_pkg::CTRL_RESET;
      end else begin
         if (wrCtrl) begin
            ctrl_r[7:1] <= regWrData[7:1];
         end
         if (perEvent) begin
            ctrl_r[mcc_pkg::BIT_PER_FLAG] <= 1'b1;
         end else if (rdCtrl) begin
            ctrl_r[mcc_pkg::BIT_PER_FLAG] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         tone_r    <= mcc_pkg::TONE_RESET[1:0];
         irqMask_r <= 2'h0;
      end else begin
         if (wrTone) begin
            tone_r <= regWrData[1:0] & mcc_pkg::TONE_FIELD_MASK;
         end
         if (wrMask) begin
            irqMask_r <= regWrData[1:0];
         end
      end
   end

   // Sticky status: bit 0 period event, bit 1 wake from active halt.
   wire [1:0] irqSet = {pwr_r == MCC_ACTIVE_HALT && pwr_nxt == MCC_RUN,
                        perEvent};
   always_ff @(posedge clock) begin
      if (rst) begin
         irqStat_r <= 2'h0;
      end else begin
         irqStat_r <= (rdIrqStat ? 2'h0 : irqStat_r) | irqSet;
      end
   end
   assign irqOut = |(irqStat_r & irqMask_r);

   // Time base counter; it runs in run, wait and active halt.
   always_ff @(posedge clock) begin
      if (rst) begin
         perCnt_r <= 18'h0;
         perSel_r <= 2'h0;
      end else if (perEvent) begin
         perCnt_r <= 18'h0;
         perSel_r <= perSelNew;
      end else if (cntRunning) begin
         perCnt_r <= perCnt_r + 18'h1;
      end
   end

   // Core clock enable from the prescaler, independent of other functions.
   always_ff @(posedge clock) begin
      if (rst) begin
         preCnt_r <= 4'h0;
         coreEn_r <= 1'b1;
      end else begin
         preCnt_r <= preCnt_r + 4'h1;
         coreEn_r <= slowMode ? preWrap : 1'b1;
      end
   end
   assign coreClockEnable = coreEn_r && pwr_r == MCC_RUN;

   // Clock out toggles at half rate and holds during active halt.
   always_ff @(posedge clock) begin
      if (rst) begin
         clkOut_r <= 1'b0;
      end else if (ctrl_r[mcc_pkg::BIT_CLK_OUT] && pwr_r == MCC_RUN) begin
         clkOut_r <= ~clkOut_r;
      end else if (!ctrl_r[mcc_pkg::BIT_CLK_OUT]) begin
         clkOut_r <= 1'b0;
      end
   end
   assign clockOutPin    = clkOut_r;
   assign clockOutEnable = !ctrl_r[mcc_pkg::BIT_CLK_OUT];

   // Tone generator, half-period counter, still running in active halt.
   always_ff @(posedge clock) begin
      if (rst) begin
         toneCnt_r  <= 17'h0;
         tone_r_lvl <= 1'b0;
      end else if (!toneOn || pwr_r == MCC_FULL_HALT) begin
         toneCnt_r  <= 17'h0;
         tone_r_lvl <= 1'b0;
      end else if (toneCnt_r >= toneHalf) begin
         toneCnt_r  <= 17'h0;
         tone_r_lvl <= ~tone_r_lvl;
      end else begin
         toneCnt_r <= toneCnt_r + 17'h1;
      end
   end
   assign tonePin    = tone_r_lvl;
   assign toneEnable = !toneOn;

   always_ff @(posedge clock) begin
      if (rst) begin
         rdData_r <= 8'h00;
      end else begin
         rdData_r <= regRead ? rdMux : 8'h00;
      end
   end
   assign regRdData = rdData_r;

   assign periodIrq   = perFlag && perIe;
   assign activeHalt  = pwr_r == MCC_ACTIVE_HALT;
   assign fullHalt    = pwr_r == MCC_FULL_HALT;
   assign wakeRequest = periodIrq && (waitMode || activeHalt);

   chk_slow_div_sel: assert property (@(posedge clock) disable iff (rst)
      !slowMode |=> coreEn_r) else $error("core enable low in normal mode");
   chk_flag_on_event: assert property (@(posedge clock) disable iff (rst)
      perEvent |=> perFlag) else $error("period flag not set");
   chk_flag_read_clr: assert property (@(posedge clock) disable iff (rst)
      rdCtrl && !perEvent |=> !perFlag) else $error("flag not cleared");
   chk_irq_request: assert property (@(posedge clock) disable iff (rst)
      perEvent && perIe && !wrCtrl |=> periodIrq)
      else $error("irq not raised on period end");
   chk_halt_entry: assert property (@(posedge clock) disable iff (rst)
      pwr_r == MCC_RUN && haltEdge && perIe |=> activeHalt)
      else $error("halt did not enter active halt");
   chk_full_halt_freeze: assert property (@(posedge clock)
      disable iff (rst) fullHalt |=> $stable(perCnt_r) || !fullHalt)
      else $error("counter moved in full halt");
   chk_period_sel_hold: assert property (@(posedge clock)
      disable iff (rst) !perEvent |=> $stable(perSel_r))
      else $error("period select changed mid period");
   chk_clk_out_stop: assert property (@(posedge clock) disable iff (rst)
      activeHalt ##1 activeHalt |-> $stable(clkOut_r))
      else $error("clock out toggled in active halt");
   chk_no_full_wake: assert property (@(posedge clock) disable iff (rst)
      fullHalt && !wakeExtS |=> fullHalt) else $error("left full halt");

   // A halt instruction seen on the synchronised line while running.
   sequence haltSeenInRun;
      pwr_r == MCC_RUN && haltEdge;
   endsequence

   // A period interrupt that arrives while the part sits in active halt.
   sequence activeWakeEvent;
      activeHalt && periodIrq;
   endsequence

   chk_full_halt_entry: assert property (@(posedge clock)
      disable iff (rst) haltSeenInRun ##0 !perIe |=> fullHalt)
      else $error("halt did not enter full halt");

   chk_active_wake: assert property (@(posedge clock)
      disable iff (rst) activeWakeEvent |=> !activeHalt)
      else $error("period irq did not wake active halt");

   chk_wake_status: assert property (@(posedge clock)
      disable iff (rst) activeWakeEvent |=> irqStat_r[1])
      else $error("wake status bit not set");

   chk_period_wrap: assert property (@(posedge clock)
      disable iff (rst) perEvent |=> perCnt_r == 18'h0)
      else $error("counter did not wrap");

   chk_period_count: assert property (@(posedge clock)
      disable iff (rst) cntRunning && !perEvent
      |=> perCnt_r == $past(perCnt_r) + 18'h1) else $error("counter stalled");

   chk_counter_bound: assert property (@(posedge clock)
      disable iff (rst) perCnt_r <= perTerm)
      else $error("counter beyond terminal count");

   chk_regs_frozen: assert property (@(posedge clock)
      disable iff (rst) regsFrozen |=> $stable(ctrl_r[7:1]))
      else $error("control changed while frozen");

   chk_tone_frozen: assert property (@(posedge clock)
      disable iff (rst) regsFrozen |=> $stable(tone_r))
      else $error("tone select changed while frozen");

   chk_mask_frozen: assert property (@(posedge clock)
      disable iff (rst) regsFrozen |=> $stable(irqMask_r))
      else $error("mask changed while frozen");

   chk_clk_out_off: assert property (@(posedge clock)
      disable iff (rst) !ctrl_r[mcc_pkg::BIT_CLK_OUT] |=> !clkOut_r)
      else $error("clock out active while deselected");

   chk_clk_out_run: assert property (@(posedge clock)
      disable iff (rst) ctrl_r[mcc_pkg::BIT_CLK_OUT] && pwr_r == MCC_RUN
      |=> clkOut_r != $past(clkOut_r)) else $error("clock out not toggling");

   chk_tone_off: assert property (@(posedge clock)
      disable iff (rst) !toneOn |=> !tone_r_lvl)
      else $error("tone pin active while off");

   chk_tone_full_halt: assert property (@(posedge clock)
      disable iff (rst) fullHalt |=> !tone_r_lvl)
      else $error("tone pin active in full halt");

   chk_ext_wake_full: assert property (@(posedge clock)
      disable iff (rst) fullHalt && wakeExtS |=> !fullHalt)
      else $error("external wake ignored in full halt");

   chk_status_set: assert property (@(posedge clock)
      disable iff (rst) perEvent |=> irqStat_r[0])
      else $error("period status bit not set");

   chk_status_clear: assert property (@(posedge clock)
      disable iff (rst) rdIrqStat && !perEvent |=> !irqStat_r[0])
      else $error("period status bit not cleared");

   chk_slow_pulse: assert property (@(posedge clock)
      disable iff (rst) slowMode |=> coreEn_r == $past(preWrap))
      else $error("slow mode enable out of step");

   chk_read_idle: assert property (@(posedge clock)
      disable iff (rst) !regRead |=> regRdData == 8'h00)
      else $error("read data not idle");

   chk_read_ctrl: assert property (@(posedge clock)
      disable iff (rst) rdCtrl |=> regRdData == $past(ctrl_r))
      else $error("control read data wrong");

   chk_sync_delay: assert property (@(posedge clock)
      disable iff (rst) haltEdge |-> $past(haltRequest, 2))
      else $error("halt edge without request");
endmodule : mcc_clock_controller

// ---- mcc_core_model.sv ----
// Core and power-mode model that drives the halt, wake and wait lines.
module mcc_core_model (
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic haltCmd,
   input  wire logic wakeCmd,
   input  wire logic waitCmd,
   input  wire logic wakeRequest,
   output logic      haltRequest,
   output logic      wakeExternal,
   output logic      waitMode
);
   timeunit 1ns;
   timeprecision 1ns;
   // The core stays in wait until the block asks for a wake.
   always_ff @(posedge clock) begin
      haltRequest  <= !rst && haltCmd;
      wakeExternal <= !rst && wakeCmd;
      waitMode     <= !rst && (waitCmd || (waitMode && !wakeRequest));
   end
endmodule : mcc_core_model

// ---- test_mcc_clock_controller.sv ----
// Self-checking bench for the main clock controller.
module test_mcc_clock_controller;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int P0 = 20;
   localparam int P3 = 50;
   logic        clock = 0;
   logic        rst = 1;
   logic [1:0]  regAddr = 2'h0;
   logic [7:0]  regWrData = 8'h00;
   logic        regWrite = 0;
   logic        regRead = 0;
   logic        haltCmd = 0;
   logic        wakeCmd = 0;
   logic        waitCmd = 0;
   logic [7:0]  regRdData, d, v;
   logic        haltRequest, wakeExternal, waitMode, coreClockEnable;
   logic        clockOutPin, clockOutEnable, tonePin, toneEnable, prev;
   logic        periodIrq, activeHalt, fullHalt, wakeRequest, irqOut;
   logic [31:0] cnt;
   int          fails = 0, tests_run = 0, cyc = 0, t1, t2, t3, n;
   mcc_clock_controller #(.PERIOD_COUNT_0(P0), .PERIOD_COUNT_1(30),
      .PERIOD_COUNT_2(40), .PERIOD_COUNT_3(P3)) DUT (.clock(clock),
      .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .haltRequest(haltRequest), .wakeExternal(wakeExternal),
      .waitMode(waitMode), .coreClockEnable(coreClockEnable),
      .clockOutPin(clockOutPin), .clockOutEnable(clockOutEnable),
      .tonePin(tonePin), .toneEnable(toneEnable), .periodIrq(periodIrq),
      .activeHalt(activeHalt), .fullHalt(fullHalt),
      .wakeRequest(wakeRequest), .irqOut(irqOut));
   mcc_core_model core (.clock(clock), .rst(rst), .haltCmd(haltCmd),
      .wakeCmd(wakeCmd), .waitCmd(waitCmd), .wakeRequest(wakeRequest),
      .haltRequest(haltRequest), .wakeExternal(wakeExternal),
      .waitMode(waitMode));
   initial begin
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 70000) begin
         fails++;
         end_of_test();
      end
   end
   function automatic logic [31:0] pulses(input int s);
      return (s == 4) ? 32'd64 : 32'd64 >> (s + 1);
   endfunction : pulses
   task automatic end_of_test;
      $display("tests_run %0d fails %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk
   task automatic tick(input int k);
      repeat (k) @(posedge clock);
      #1;
   endtask : tick
   task automatic wr(input logic [1:0] a, input logic [7:0] dd);
      @(posedge clock);
      regAddr   <= a;
      regWrData <= dd;
      regWrite  <= 1'b1;
      @(posedge clock);
      regWrite  <= 1'b0;
   endtask : wr
   task automatic rd(input logic [1:0] a);
      @(posedge clock);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clock);
      regRead <= 1'b0;
      #1 d = regRdData;
   endtask : rd
   task automatic waitIrq(output int t);
      for (int i = 0; i < 100 && periodIrq !== 1'b1; i++) tick(1);
      t = cyc;
   endtask : waitIrq
   task automatic halt(input logic full);
      @(posedge clock);
      haltCmd <= 1'b1;
      for (n = 0; n < 10 && (full ? fullHalt : activeHalt) !== 1'b1; n++)
         tick(1);
      chk({activeHalt, fullHalt}, {!full, full});
   endtask : halt
   task automatic wake;
      @(posedge clock);
      haltCmd <= 1'b0;
      wakeCmd <= 1'b1;
      for (n = 0; n < 10 && (activeHalt | fullHalt) !== 1'b0; n++) tick(1);
      @(posedge clock);
      wakeCmd <= 1'b0;
      chk({activeHalt, fullHalt}, 2'b00);
   endtask : wake
   initial begin
      v = $urandom(70084);
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      rd(mcc_pkg::ADDR_CTRL_STATUS);
      chk({d, coreClockEnable, clockOutEnable, toneEnable},
          {mcc_pkg::CTRL_RESET, 3'b111});
      v = $urandom() & 8'hfe;
      wr(mcc_pkg::ADDR_CTRL_STATUS, v);
      rd(mcc_pkg::ADDR_CTRL_STATUS);
      chk(d & 8'hfe, v);
      v = $urandom();
      wr(mcc_pkg::ADDR_TONE, v);
      rd(mcc_pkg::ADDR_TONE);
      chk(d, v & {6'h00, mcc_pkg::TONE_FIELD_MASK});
      $display("test registers done");
      for (int s = 0; s < 5; s++) begin
         wr(2'h0, (s < 4) ? {1'b0, s[1:0], 1'b1, 4'h0} : 8'h00);
         tick(20);
         cnt = 0;
         repeat (64) begin
            tick(1);
            cnt = cnt + coreClockEnable;
         end
         chk(cnt, pulses(s));
      end
      wr(2'h0, 8'h80);
      tick(3);
      prev = clockOutPin;
      tick(1);
      chk({clockOutEnable, clockOutPin ^ prev}, 2'b01);
      $display("test prescaler and clock out done");
      wr(2'h0, 8'h02);
      rd(2'h0);
      waitIrq(t1);
      rd(2'h0);
      chk({d[0], periodIrq}, 2'b10);
      wr(2'h0, 8'h0e);
      waitIrq(t2);
      rd(2'h0);
      waitIrq(t3);
      chk(t2 - t1, P0);
      chk(t3 - t2, P3);
      rd(mcc_pkg::ADDR_IRQ_STATUS);
      rd(2'h0);
      wr(mcc_pkg::ADDR_IRQ_MASK, 8'h01);
      chk(irqOut, 1'b0);
      waitIrq(t1);
      tick(2);
      chk(irqOut, 1'b1);
      rd(mcc_pkg::ADDR_IRQ_STATUS);
      chk({d[0], irqOut}, 2'b10);
      wr(mcc_pkg::ADDR_IRQ_MASK, 8'h00);
      rd(2'h0);
      waitIrq(t1);
      tick(2);
      chk({periodIrq, irqOut}, 2'b10);
      $display("test time base done");
      wr(2'h1, 8'h00);
      wr(2'h0, 8'h82);
      rd(2'h0);
      waitIrq(t1);
      rd(2'h0);
      halt(1'b0);
      prev = clockOutPin;
      tick(3);
      chk(clockOutPin, prev);
      wr(2'h1, 8'h01);
      for (n = 0; n < 60 && wakeRequest !== 1'b1; n++) tick(1);
      chk(wakeRequest, 1'b1);
      wake();
      rd(2'h1);
      chk(d, 8'h00);
      wr(2'h0, 8'h00);
      halt(1'b1);
      tick(120);
      chk({fullHalt, wakeRequest}, 2'b10);
      wake();
      wr(2'h0, 8'h02);
      rd(2'h0);
      @(posedge clock);
      waitCmd <= 1'b1;
      @(posedge clock);
      waitCmd <= 1'b0;
      #1 chk(waitMode, 1'b1);
      for (n = 0; n < 60 && waitMode !== 1'b0; n++) tick(1);
      chk(waitMode, 1'b0);
      $display("test power modes done");
      for (int s = 0; s < 4; s++) begin
         wr(2'h1, s[7:0]);
         tick(2);
         chk(toneEnable, s == 0);
      end
      wr(2'h1, 8'h01);
      prev = tonePin;
      for (n = 0; n < 60000 && tonePin === prev; n++) tick(1);
      prev = tonePin;
      for (n = 0; n < 60000 && tonePin === prev; n++) tick(1);
      chk(n, mcc_pkg::TONE_HALF_2K);
      $display("test tone done");
      end_of_test();
   end
endmodule : test_mcc_clock_controller
